// *** src/dpdr_pkg.sv ***
`default_nettype none
package dpdr_pkg;

  // widths
  localparam int LOC_W = 6;
  localparam int DIGIT_W = 4;
  localparam int DIGITS = 16;
  localparam int CNT_W = 4;
  localparam int DIV_W = 3;

  // reset and preset values
  localparam logic [LOC_W-1:0] LOC_MINUS_ONE = 6'h3F;
  localparam logic [LOC_W-1:0] LOC_ONE = 6'h01;
  localparam logic signed [LOC_W-1:0] LOC_SIXTEEN = 6'sh10;
  localparam int LOC_SIGN_BIT = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [DIGIT_W-1:0] DIGIT_ZERO = 4'h0;
  localparam logic [DIV_W-1:0] DIV_ZERO = 3'h0;
  localparam logic [DIV_W-1:0] DIV_ONE = 3'h1;
  localparam logic [DIV_W-1:0] DIV_LAST = 3'h7;

  // denominator register shift actions
  typedef enum logic [2:0] {
    DPDR_SHIFT_HOLD = 3'b000,
    DPDR_LOAD_PLUGIN = 3'b001,
    DPDR_LOAD_EVENTS = 3'b010,
    DPDR_SHIFT_UP = 3'b011,
    DPDR_SHIFT_DOWN = 3'b100,
    DPDR_CLEAR_DIGIT = 3'b101
  } dpdr_shift_t;

  // sequencer and front-panel inputs, sampled one clock ahead of use
  typedef struct packed {
    logic reg_tick;
    logic const_reset_n;
    logic load_point_from_plugin_n;
    logic result_reset_n;
    logic result_locator_clock;
    logic result_direction;
    logic nano_multiplier;
    logic resolution_below_three;
    logic fixed_position;
    logic [DIGIT_W-1:0] front_display_position;
    logic clear_denominator_counter_n;
    logic denominator_clock_enable;
    dpdr_shift_t denominator_shift_code;
    logic [DIGIT_W-1:0] events_scaler_digits;
    logic [DIGIT_W-1:0] plugin_digit;
    logic [DIGIT_W-1:0] shift_in_digit;
    logic [LOC_W-1:0] point_code_in;
    logic plugin_transmit; // one copy for write guard and pin enable
  } dpdr_cmd_t;

  typedef struct packed {
    dpdr_cmd_t cmd;
    logic [LOC_W-1:0] const_point_locator;
    logic [LOC_W-1:0] result_point_locator;
    logic [CNT_W-1:0] denominator_digit_counter;
    logic [DIGIT_W-1:0] denominator_out;
    logic [DIGITS-1:0][DIGIT_W-1:0] denominator_register;
  } dpdr_state_t;

  typedef struct packed {
    logic [DIV_W-1:0] count;
    logic display_clock;
  } dpdr_div_state_t;

endpackage
`default_nettype wire

// *** src/dpdr_display_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpdr_display_divider (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // constant point-locator clock pulses and display phase
  input wire logic const_locator_clock,
  input wire logic display_cycle,
  // one-cycle pulse on every eighth locator clock inside the display cycle
  output logic display_clock
);

  dpdr_pkg::dpdr_div_state_t s_reg;
  dpdr_pkg::dpdr_div_state_t s_next;

  // count locator pulses only inside the display cycle so each one starts
  // from a known phase
  always_comb begin
    s_next = s_reg;
    s_next.display_clock = 1'b0;
    if (!display_cycle) begin
      s_next.count = dpdr_pkg::DIV_ZERO;
    end else if (const_locator_clock) begin
      s_next.count = s_reg.count + dpdr_pkg::DIV_ONE;
      s_next.display_clock = (s_reg.count == dpdr_pkg::DIV_LAST);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign display_clock = s_reg.display_clock;

endmodule
`default_nettype wire

// *** src/dpdr_regs.sv ***
// What this block does
// - constant locator reset forces all ones
// - load command copies plug-in point code
// - result locator reset forces all ones
// - in-range flag; request alignment otherwise, unless nano multiplier
// - flag result locator below sixteen
// - transmit high drives data, else accepts
// - clear command zeroes digit counter
// - enable advances digit counter per tick
// - three-bit code selects register shift
// - digit counter output as strobe code
// - low resolution freezes point stepping
// - events scaler digits enter register
// - fixed mode steps toward panel position
// - direction high decrements, low increments
// - display clock is locator clock over eight
// - nano multiplier inverts step direction
`timescale 1ns/1ps
`default_nettype none
module dpdr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register timing from the sequencer
  input wire logic reg_tick,
  input wire logic const_locator_clock,
  input wire logic display_cycle,
  // point-locator commands, active low
  input wire logic const_reset_n,
  input wire logic load_point_from_plugin_n,
  input wire logic result_reset_n,
  // result stepping
  input wire logic result_locator_clock,
  input wire logic result_direction,
  input wire logic nano_multiplier,
  input wire logic resolution_below_three,
  input wire logic fixed_position,
  input wire logic [3:0] front_display_position,
  // denominator controls
  input wire logic clear_denominator_counter_n,
  input wire logic denominator_clock_enable,
  input wire logic [2:0] denominator_shift_code,
  input wire logic [3:0] events_scaler_digits,
  input wire logic [3:0] shift_in_digit,
  // shared point-code lines
  input wire logic [5:0] point_code_in,
  output logic [5:0] point_code_out,
  output logic point_code_oe_n,
  // shared denominator data lines
  input wire logic plugin_transmit,
  input wire logic [3:0] denominator_data_in,
  output logic [3:0] denominator_data_out,
  output logic denominator_data_oe_n,
  // qualifiers and codes to the sequencer and display
  output logic [5:0] const_point_locator,
  output logic [5:0] result_point_locator,
  output logic result_in_range,
  output logic auto_point_align,
  output logic result_below_sixteen,
  output logic [3:0] denominator_digit_counter,
  output logic display_clock
);

  dpdr_pkg::dpdr_state_t s_reg;
  dpdr_pkg::dpdr_state_t s_next;
  dpdr_pkg::dpdr_cmd_t c;
  logic signed [5:0] result_s;
  logic signed [5:0] target_s;

  assign c = s_reg.cmd;
  assign result_s = $signed(s_reg.result_point_locator);
  assign target_s = $signed({2'h0, c.front_display_position});

  // every command is registered first so all register updates act one clock later,
  // keeping the sequencer's decode glitches out of the counters; point_code_oe_n
  // alone follows load_point_from_plugin_n unregistered
  always_comb begin
    s_next = s_reg;
    s_next.cmd.reg_tick = reg_tick;
    s_next.cmd.const_reset_n = const_reset_n;
    s_next.cmd.load_point_from_plugin_n = load_point_from_plugin_n;
    s_next.cmd.result_reset_n = result_reset_n;
    s_next.cmd.result_locator_clock = result_locator_clock;
    s_next.cmd.result_direction = result_direction;
    s_next.cmd.nano_multiplier = nano_multiplier;
    s_next.cmd.resolution_below_three = resolution_below_three;
    s_next.cmd.fixed_position = fixed_position;
    s_next.cmd.front_display_position = front_display_position;
    s_next.cmd.clear_denominator_counter_n = clear_denominator_counter_n;
    s_next.cmd.denominator_clock_enable = denominator_clock_enable;
    s_next.cmd.denominator_shift_code =
      dpdr_pkg::dpdr_shift_t'(denominator_shift_code);
    s_next.cmd.events_scaler_digits = events_scaler_digits;
    s_next.cmd.plugin_digit = denominator_data_in;
    s_next.cmd.shift_in_digit = shift_in_digit;
    s_next.cmd.point_code_in = point_code_in;
    // sampled with the other commands so the write guard and the pin
    // enable never disagree within a cycle
    s_next.cmd.plugin_transmit = plugin_transmit;
    // digit presented on the data lines follows the counter
    s_next.denominator_out =
      s_reg.denominator_register[s_reg.denominator_digit_counter];
    if (c.reg_tick) begin
      // constant locator: reset has priority over plug-in load
      if (!c.const_reset_n) begin
        s_next.const_point_locator = dpdr_pkg::LOC_MINUS_ONE;
      end else if (!c.load_point_from_plugin_n) begin
        s_next.const_point_locator = c.point_code_in;
      end
      // result locator
      if (!c.result_reset_n) begin
        s_next.result_point_locator = dpdr_pkg::LOC_MINUS_ONE;
      end else if (c.result_locator_clock && !c.resolution_below_three) begin
        // low resolution leaves the point where it is
        if (c.fixed_position) begin
          if (result_s < target_s) begin
            s_next.result_point_locator =
              s_reg.result_point_locator + dpdr_pkg::LOC_ONE;
          end else if (result_s > target_s) begin
            s_next.result_point_locator =
              s_reg.result_point_locator - dpdr_pkg::LOC_ONE;
          end
        end else if (c.result_direction ^ c.nano_multiplier) begin
          s_next.result_point_locator =
            s_reg.result_point_locator - dpdr_pkg::LOC_ONE;
        end else begin
          s_next.result_point_locator =
            s_reg.result_point_locator + dpdr_pkg::LOC_ONE;
        end
      end
      // digit counter: clear wins over advance
      if (!c.clear_denominator_counter_n) begin
        s_next.denominator_digit_counter = dpdr_pkg::CNT_ZERO;
      end else if (c.denominator_clock_enable) begin
        s_next.denominator_digit_counter =
          s_reg.denominator_digit_counter + dpdr_pkg::CNT_ONE;
      end
      // shift action on the register selected by the code
      case (c.denominator_shift_code)
        dpdr_pkg::DPDR_LOAD_PLUGIN: begin
          if (!c.plugin_transmit) begin
            s_next.denominator_register[s_reg.denominator_digit_counter] =
              c.plugin_digit;
          end
        end
        dpdr_pkg::DPDR_LOAD_EVENTS: begin
          s_next.denominator_register[s_reg.denominator_digit_counter] =
            c.events_scaler_digits;
        end
        dpdr_pkg::DPDR_SHIFT_UP: begin
          s_next.denominator_register = {
            s_reg.denominator_register[dpdr_pkg::DIGITS-2:0],
            c.shift_in_digit};
        end
        dpdr_pkg::DPDR_SHIFT_DOWN: begin
          s_next.denominator_register = {c.shift_in_digit,
            s_reg.denominator_register[dpdr_pkg::DIGITS-1:1]};
        end
        dpdr_pkg::DPDR_CLEAR_DIGIT: begin
          s_next.denominator_register[s_reg.denominator_digit_counter] =
            dpdr_pkg::DIGIT_ZERO;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.cmd.const_reset_n <= 1'b1;
      s_reg.cmd.load_point_from_plugin_n <= 1'b1;
      s_reg.cmd.result_reset_n <= 1'b1;
      s_reg.cmd.clear_denominator_counter_n <= 1'b1;
      s_reg.const_point_locator <= dpdr_pkg::LOC_MINUS_ONE;
      s_reg.result_point_locator <= dpdr_pkg::LOC_MINUS_ONE;
    end else begin
      s_reg <= s_next;
    end
  end

  // shared lines: the device drives the point code except while loading
  assign point_code_out = s_reg.result_point_locator;
  assign point_code_oe_n = ~load_point_from_plugin_n;
  assign denominator_data_out = s_reg.denominator_out;
  assign denominator_data_oe_n = ~c.plugin_transmit;

  // qualifiers; sign bit clear means the point is in the viewable range
  assign const_point_locator = s_reg.const_point_locator;
  assign result_point_locator = s_reg.result_point_locator;
  assign result_in_range =
    ~s_reg.result_point_locator[dpdr_pkg::LOC_SIGN_BIT];
  assign auto_point_align = ~result_in_range & ~c.nano_multiplier;
  assign result_below_sixteen = (result_s < dpdr_pkg::LOC_SIXTEEN);
  assign denominator_digit_counter =
    s_reg.denominator_digit_counter;

  dpdr_display_divider u_div (
    .clk(clk),
    .srst(srst),
    .const_locator_clock(const_locator_clock),
    .display_cycle(display_cycle),
    .display_clock(display_clock)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence tick_s;
    c.reg_tick;
  endsequence

  sequence plain_step_s;
    tick_s ##0 c.result_reset_n && c.result_locator_clock
      && !c.resolution_below_three && !c.fixed_position
      && !c.nano_multiplier;
  endsequence

  const_reset_a: assert property (tick_s ##0 !c.const_reset_n
    |=> const_point_locator == 6'h3F)
    else $error("constant locator not preset to minus one");

  const_load_a: assert property (tick_s ##0 c.const_reset_n
    && !c.load_point_from_plugin_n
    |=> const_point_locator == $past(c.point_code_in))
    else $error("constant locator did not take plug-in code");

  result_reset_a: assert property (tick_s ##0 !c.result_reset_n
    |=> result_point_locator == 6'h3F && !result_in_range
    && result_below_sixteen)
    else $error("result locator not preset to minus one");

  align_request_a: assert property (
    result_point_locator[dpdr_pkg::LOC_SIGN_BIT]
    && !c.nano_multiplier |-> auto_point_align)
    else $error("alignment request missing out of range");

  below_sixteen_a: assert property (!result_point_locator[5]
    && result_point_locator[4] |-> !result_below_sixteen)
    else $error("below sixteen wrong at or above sixteen");

  data_drive_a: assert property ($rose(plugin_transmit)
    |=> !denominator_data_oe_n)
    else $error("data lines not driven one clock after transmit");

  counter_clear_a: assert property (tick_s ##0
    !c.clear_denominator_counter_n
    |=> denominator_digit_counter == 4'h0)
    else $error("digit counter not cleared");

  counter_step_a: assert property (tick_s ##0
    c.clear_denominator_counter_n && c.denominator_clock_enable
    |=> denominator_digit_counter
    == $past(denominator_digit_counter) + 4'h1)
    else $error("digit counter did not advance");

  counter_hold_a: assert property (!c.reg_tick
    |=> $stable(denominator_digit_counter))
    else $error("digit counter moved without a tick");

  // the digit must be read back at the index it was written to, so the
  // counter has to stand still across the write
  events_load_a: assert property (tick_s ##0
    c.denominator_shift_code == dpdr_pkg::DPDR_LOAD_EVENTS
    ##1 denominator_digit_counter == $past(denominator_digit_counter)
    ##1 1'b1 |-> denominator_data_out == $past(c.events_scaler_digits, 2))
    else $error("events digit not stored");

  step_down_a: assert property (plain_step_s
    ##0 c.result_direction
    |=> result_point_locator
    == $past(result_point_locator) - 6'h01)
    else $error("result locator did not decrement");

  step_up_a: assert property (plain_step_s
    ##0 !c.result_direction
    |=> result_point_locator
    == $past(result_point_locator) + 6'h01)
    else $error("result locator did not increment");

  freeze_a: assert property (tick_s ##0 c.result_reset_n
    && c.resolution_below_three
    |=> $stable(result_point_locator))
    else $error("point moved at low resolution");

  fixed_stop_a: assert property (tick_s ##0 c.result_reset_n
    && c.fixed_position && result_s == target_s
    |=> $stable(result_point_locator))
    else $error("fixed mode moved past panel position");

endmodule
`default_nettype wire

// *** dv/dpdr_plugin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpdr_plugin_model (
  // device side of the shared lines
  input wire logic [5:0] point_code_out,
  input wire logic point_code_oe_n,
  input wire logic [3:0] denominator_data_out,
  input wire logic denominator_data_oe_n,
  input wire logic plugin_transmit,
  // values the plug-in presents
  input wire logic [5:0] pi_point,
  input wire logic [3:0] pi_digit,
  // resolved line levels
  output logic [5:0] point_code_in,
  output logic [3:0] denominator_data_in
);
  // plug-in owns the point lines only while the device lets go
  always_comb begin
    point_code_in = point_code_oe_n ? pi_point : point_code_out;
    if (!plugin_transmit) begin
      denominator_data_in = pi_digit;
    end else if (!denominator_data_oe_n) begin
      denominator_data_in = denominator_data_out;
    end else begin
      // nobody drives: show a value that cannot pass for stale data
      denominator_data_in = ~pi_digit;
    end
  end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reg_tick, const_locator_clock, display_cycle, const_reset_n;
  logic load_point_from_plugin_n, result_reset_n, result_locator_clock;
  logic result_direction, nano_multiplier, resolution_below_three;
  logic fixed_position, clear_denominator_counter_n;
  logic denominator_clock_enable, plugin_transmit, point_code_oe_n;
  logic denominator_data_oe_n, result_in_range, auto_point_align;
  logic result_below_sixteen, display_clock;
  logic [2:0] denominator_shift_code;
  logic [3:0] front_display_position, events_scaler_digits, shift_in_digit;
  logic [3:0] denominator_data_in, denominator_data_out, pi_digit;
  logic [3:0] denominator_digit_counter;
  logic [5:0] point_code_in, point_code_out, pi_point;
  logic [5:0] const_point_locator, result_point_locator;
  int error_cnt = 0;
  int comparisons = 0;
  int dclk_cnt = 0;

  dpdr_regs DUT (.clk, .srst, .reg_tick, .const_locator_clock,
    .display_cycle, .const_reset_n, .load_point_from_plugin_n,
    .result_reset_n, .result_locator_clock, .result_direction,
    .nano_multiplier, .resolution_below_three, .fixed_position,
    .front_display_position, .clear_denominator_counter_n,
    .denominator_clock_enable, .denominator_shift_code,
    .events_scaler_digits, .shift_in_digit, .point_code_in,
    .point_code_out, .point_code_oe_n, .plugin_transmit,
    .denominator_data_in, .denominator_data_out, .denominator_data_oe_n,
    .const_point_locator, .result_point_locator, .result_in_range,
    .auto_point_align, .result_below_sixteen, .denominator_digit_counter,
    .display_clock);

  dpdr_plugin_model PI (.point_code_out, .point_code_oe_n,
    .denominator_data_out, .denominator_data_oe_n, .plugin_transmit,
    .pi_point, .pi_digit, .point_code_in, .denominator_data_in);

  always #10 clk = ~clk;

  // display clock pulses are one cycle wide; count them mid-cycle, where
  // they are settled, so the count never races the launching edge
  always @(negedge clk) begin
    if (display_clock === 1'b1) dclk_cnt++;
  end

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task final_report;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one-shot commands back to their quiet levels
  task idle;
    reg_tick <= 1'b0;
    const_reset_n <= 1'b1;
    load_point_from_plugin_n <= 1'b1;
    result_reset_n <= 1'b1;
    result_locator_clock <= 1'b0;
    clear_denominator_counter_n <= 1'b1;
    denominator_clock_enable <= 1'b0;
    denominator_shift_code <= 3'h0;
  endtask

  // one register tick; commands sampled a clock ahead, so wait it out
  task pulse;
    reg_tick <= 1'b1;
    @(posedge clk);
    idle();
    repeat (3) @(posedge clk);
  endtask

  task steps(input int n);
    repeat (n) begin
      result_locator_clock <= 1'b1;
      pulse();
    end
  endtask

  task set_cnt(input int k);
    clear_denominator_counter_n <= 1'b0;
    pulse();
    repeat (k) begin
      denominator_clock_enable <= 1'b1;
      pulse();
    end
  endtask

  task put(input logic [2:0] code);
    denominator_shift_code <= code;
    pulse();
  endtask

  // digits leave only while transmitting, strobed by the counter
  task see(input int k, input logic [3:0] exp);
    plugin_transmit <= 1'b1;
    set_cnt(k);
    chk("data_oe_n", 8'h00, {7'h00, denominator_data_oe_n});
    chk("digit", {4'h0, exp}, {4'h0, denominator_data_out});
  endtask

  // n constant-locator pulses, two quiet clocks after each
  task lk(input int n);
    repeat (n) begin
      const_locator_clock <= 1'b1;
      @(posedge clk);
      const_locator_clock <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial begin
    idle();
    {const_locator_clock, display_cycle, result_direction} <= 3'h0;
    {nano_multiplier, resolution_below_three, fixed_position} <= 3'h0;
    {front_display_position, events_scaler_digits} <= 8'h00;
    {shift_in_digit, pi_digit, pi_point} <= 14'h0000;
    plugin_transmit <= 1'b0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("const_loc", 8'h3F, {2'h0, const_point_locator});
    chk("below16", 8'h01, {7'h00, result_below_sixteen});
    chk("align", 8'h01, {7'h00, auto_point_align});
    // plug-in load turns the point lines around
    pi_point <= 6'h05;
    load_point_from_plugin_n <= 1'b0;
    @(posedge clk);
    chk("point_oe_n", 8'h01, {7'h00, point_code_oe_n});
    pulse();
    chk("const_loc", 8'h05, {2'h0, const_point_locator});
    chk("point_oe_n", 8'h00, {7'h00, point_code_oe_n});
    const_reset_n <= 1'b0;
    load_point_from_plugin_n <= 1'b0;
    pulse();
    chk("const_loc", 8'h3F, {2'h0, const_point_locator});
    result_reset_n <= 1'b0;
    result_locator_clock <= 1'b1;
    pulse();
    chk("result_loc", 8'h3F, {2'h0, result_point_locator});
    steps(1);
    chk("result_loc", 8'h00, {2'h0, result_point_locator});
    chk("in_range", 8'h01, {7'h00, result_in_range});
    chk("align", 8'h00, {7'h00, auto_point_align});
    steps(15);
    chk("below16", 8'h01, {7'h00, result_below_sixteen});
    steps(1);
    chk("below16", 8'h00, {7'h00, result_below_sixteen});
    result_direction <= 1'b1;
    steps(1);
    chk("result_loc", 8'h0F, {2'h0, result_point_locator});
    {result_direction, nano_multiplier} <= 2'b01;
    steps(1);
    chk("result_loc", 8'h0E, {2'h0, result_point_locator});
    resolution_below_three <= 1'b1;
    steps(1);
    chk("result_loc", 8'h0E, {2'h0, result_point_locator});
    chk("point_out", 8'h0E, {2'h0, point_code_out});
    {resolution_below_three, nano_multiplier, fixed_position} <= 3'b001;
    front_display_position <= 4'h3;
    steps(14);
    chk("result_loc", 8'h03, {2'h0, result_point_locator});
    front_display_position <= 4'hA;
    steps(9);
    chk("result_loc", 8'h0A, {2'h0, result_point_locator});
    fixed_position <= 1'b0;
    // out of range but nano measurement: no alignment request
    result_reset_n <= 1'b0;
    nano_multiplier <= 1'b1;
    pulse();
    chk("align", 8'h00, {7'h00, auto_point_align});
    nano_multiplier <= 1'b0;
    repeat (3) @(posedge clk);
    chk("align", 8'h01, {7'h00, auto_point_align});
    set_cnt(5);
    pulse();
    chk("counter", 8'h05, {4'h0, denominator_digit_counter});
    clear_denominator_counter_n <= 1'b0;
    denominator_clock_enable <= 1'b1;
    pulse();
    chk("counter", 8'h00, {4'h0, denominator_digit_counter});
    events_scaler_digits <= 4'h9;
    put(dpdr_pkg::DPDR_LOAD_EVENTS);
    pi_digit <= 4'h6;
    set_cnt(1);
    put(dpdr_pkg::DPDR_LOAD_PLUGIN);
    plugin_transmit <= 1'b1;
    pi_digit <= 4'h3;
    put(dpdr_pkg::DPDR_LOAD_PLUGIN);
    see(0, 4'h9);
    see(1, 4'h6);
    plugin_transmit <= 1'b0;
    repeat (3) @(posedge clk);
    chk("data_oe_n", 8'h01, {7'h00, denominator_data_oe_n});
    set_cnt(0);
    shift_in_digit <= 4'hA;
    put(dpdr_pkg::DPDR_SHIFT_UP);
    see(1, 4'h9);
    see(2, 4'h6);
    shift_in_digit <= 4'hB;
    put(dpdr_pkg::DPDR_SHIFT_DOWN);
    see(0, 4'h9);
    see(15, 4'hB);
    put(dpdr_pkg::DPDR_CLEAR_DIGIT);
    see(15, 4'h0);
    put(3'h6);
    put(3'h7);
    put(dpdr_pkg::DPDR_SHIFT_HOLD);
    see(0, 4'h9);
    // divider counts locator pulses only inside the display cycle, and
    // leaving the cycle restarts the count
    display_cycle <= 1'b1;
    lk(7);
    chk("dclk_cnt", 8'h00, dclk_cnt[7:0]);
    lk(1);
    chk("dclk_cnt", 8'h01, dclk_cnt[7:0]);
    lk(4);
    display_cycle <= 1'b0;
    lk(1);
    display_cycle <= 1'b1;
    lk(7);
    chk("dclk_cnt", 8'h01, dclk_cnt[7:0]);
    lk(1);
    chk("dclk_cnt", 8'h02, dclk_cnt[7:0]);
    final_report();
  end
endmodule
`default_nettype wire
